// ---- core/bcmc_pkg.sv ----
// Purpose: Shared constants and types for the charge-mode control block
// Assumes: 10 MHz core clock
// Notes:   APB map, time bases, range encoding
package bcmc_pkg;
  // ****************************************
  // Time bases
  // ****************************************
  localparam longint CLK_HZ        = 10_000_000;
  localparam longint FAST_MS       = 32;
  localparam longint QUICK_MS      = 250;
  localparam longint FULL_S        = 30;
  localparam longint TIMEOUT_S     = 175;
  localparam int     FAST_CYC      = int'(FAST_MS * CLK_HZ / 1000);
  localparam int     QUICK_CYC     = int'(QUICK_MS * CLK_HZ / 1000);
  localparam int     FULL_CYC      = int'(FULL_S * CLK_HZ);
  localparam int     TIMEOUT_CYC   = int'(TIMEOUT_S * CLK_HZ);
  localparam logic [3:0] SETTLE_CYC = 4'h8;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ADDR_CURRENT = 8'h00;
  localparam logic [7:0] ADDR_VOLTAGE = 8'h04;
  localparam logic [7:0] ADDR_MODE    = 8'h08;
  localparam logic [7:0] ADDR_STATUS  = 8'h0C;
  localparam logic [7:0] ADDR_DRIVE   = 8'h10;
  localparam int MODE_INHIBIT = 0;
  localparam int MODE_CLEAR   = 1;
  localparam logic [15:0] REQ_RESET    = 16'h0000;
  localparam logic [11:0] WAKE_CURRENT = 12'h050;
  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [4:0] {
    RNG_UNDER = 5'b00001,
    RNG_HOT   = 5'b00010,
    RNG_IDEAL = 5'b00100,
    RNG_COLD  = 5'b01000,
    RNG_OVER  = 5'b10000
  } bcmc_range_t;
  typedef struct packed {
    logic rangeOver;
    logic rangeCold;
    logic rangeHot;
    logic rangeUnder;
    logic present;
  } bcmc_flags_t;
  typedef struct packed {
    logic       selA;
    logic       selB;
    logic [1:0] thrIdx;
    logic       hystLow;
  } bcmc_probe_t;
  function automatic bcmc_flags_t bcmc_range_flags(input bcmc_range_t r);
    bcmc_flags_t f;
    f = '0;
    case (r)
      RNG_UNDER: f = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
      RNG_HOT:   f = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
      RNG_IDEAL: f = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
      RNG_COLD:  f = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
      default:   f = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    endcase
    return f;
  endfunction
endpackage

// ---- core/bcmc_sense_decoder.sv ----
// Purpose: Threshold walk over the battery sense line with hysteresis
// Assumes: aboveThr is the comparator result for the threshold on probe
// Notes:   Quick pass checks only the top threshold unless the last range was overrange
`timescale 1ns/1ps
module bcmc_sense_decoder import bcmc_pkg::*; (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire logic        startFull,
  input  wire logic        startQuick,
  input  wire logic        aboveThr,
  output bcmc_probe_t      probe,
  output bcmc_range_t      range,
  output logic             busy
);
  typedef enum logic [2:0] {
    SD_IDLE   = 3'b001,
    SD_SETTLE = 3'b010,
    SD_DECIDE = 3'b100
  } bcmc_sd_state_t;
  bcmc_sd_state_t state_r;
  logic [1:0]     idx_r;
  logic [3:0]     settle_r;
  logic           quick_r;
  bcmc_range_t    range_r;
  // Rank 4 is overrange, rank 0 underrange
  function automatic logic [2:0] rankOf(input bcmc_range_t r);
    case (r)
      RNG_OVER:  return 3'h4;
      RNG_COLD:  return 3'h3;
      RNG_IDEAL: return 3'h2;
      RNG_HOT:   return 3'h1;
      default:   return 3'h0;
    endcase
  endfunction
  function automatic bcmc_range_t rangeOf(input logic [2:0] k);
    case (k)
      3'h4:    return RNG_OVER;
      3'h3:    return RNG_COLD;
      3'h2:    return RNG_IDEAL;
      3'h1:    return RNG_HOT;
      default: return RNG_UNDER;
    endcase
  endfunction
  // ****************************************
  // Threshold walk
  // ****************************************
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_r  <= SD_IDLE;
      idx_r    <= 2'h0;
      settle_r <= 4'h0;
      quick_r  <= 1'b0;
      range_r  <= RNG_OVER;
    end else if (ce) begin
      case (state_r)
        SD_IDLE: if (startFull || startQuick) begin
          idx_r    <= 2'h0;
          quick_r  <= startQuick && !startFull;
          settle_r <= SETTLE_CYC;
          state_r  <= SD_SETTLE;
        end
        SD_SETTLE: begin
          settle_r <= settle_r - 4'h1;
          if (settle_r == 4'h1) state_r <= SD_DECIDE;
        end
        SD_DECIDE: begin
          state_r <= SD_IDLE;
          if (aboveThr) begin
            range_r <= rangeOf(3'h4 - {1'b0, idx_r});
          end else if (idx_r == 2'h3) begin
            range_r <= RNG_UNDER;
          end else if (quick_r && range_r != RNG_OVER) begin
            range_r <= range_r;
          end else begin
            idx_r    <= idx_r + 2'h1;
            settle_r <= SETTLE_CYC;
            state_r  <= SD_SETTLE;
          end
        end
        default: state_r <= SD_IDLE;
      endcase
    end
  end
  // Upper thresholds drive B and read A; lower ones the reverse
  always_comb begin
    probe.selB    = (state_r != SD_IDLE) && !idx_r[1];
    probe.selA    = (state_r != SD_IDLE) && idx_r[1];
    probe.thrIdx  = idx_r;
    probe.hystLow = rankOf(range_r) >= (3'h4 - {1'b0, idx_r});
  end
  assign range = range_r;
  assign busy  = state_r != SD_IDLE;
endmodule

// ---- core/bcmc_charge_ctrl.sv ----
// What this block does
// - Wake-up charging only with acceptable sense range and adapter detected
// - Wake-up starts for a new battery lacking both charge requests
// - Timeout during cold or underrange ends wake-up charging
// - Overrange, hot, adapter loss, alarm or inhibit end wake-up
// - Both requests written moves wake-up into controlled charging
// - External enable low pauses wake-up; timer not restarted
// - Low input supply pauses wake-up; timer not restarted
// - Controlled start needs non-zero requests, good range, adapter
// - Both requests must be rewritten each timeout, else controlled stops
// - Overrange, hot, adapter loss, alarm or clear bit stop controlled
// - Inhibit halts controlled; clearing resumes with stored requests
// - Enable pin low or low supply pause controlled, resume later
// - Writing zero to either request stops controlled charging
// - With adapter, full sense sample about every 32 ms
// - Thresholds tested top down, stopping once range known
// - Threshold shifted by previous range for hysteresis
// - Upper thresholds drive B read A; lower drive A read B
// - Without adapter, sample every 250 ms, full pass every 30 s
// - Range maps to over, cold, hot, under and present flags
// - Current strap picks 1023/2046/3068/4092 mA ceilings, granularity 1/2/4/4
// - Voltage strap picks one of five ceilings, 16 mV granularity
// - Wake-up forces a fixed 80 mA current request
//
// Purpose: Charge-mode sequencing with APB registers
// Assumes: Comparator and strap codes come from analogue front end
// Notes:   Zero-wait APB slave
//
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
module bcmc_charge_ctrl import bcmc_pkg::*; #(
  parameter int FAST_CYCLES    = FAST_CYC,
  parameter int QUICK_CYCLES   = QUICK_CYC,
  parameter int FULL_CYCLES    = FULL_CYC,
  parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        dividedInputSense,
  input  wire logic        inputSupplyOk,
  input  wire logic        alarmBlockFlag,
  input  wire logic        senseAbove,
  input  wire logic [1:0]  currentCeilingStrap,
  input  wire logic [2:0]  voltageCeilingStrap,
  input  wire logic        chargerEnableIn,
  output logic             chargerEnableOut,
  output logic             chargerEnableOe,
  output logic             dividerASelect,
  output logic             dividerBSelect,
  output logic [1:0]       thresholdIndex,
  output logic             thresholdLow,
  output logic             wakeActive,
  output logic             chargeActive,
  output logic [11:0]      currentDrive,
  output logic [15:0]      voltageDrive
);
  // ****************************************
  // Elaboration checks
  // ****************************************
  if (FAST_CYCLES < 32 || QUICK_CYCLES < 32 || FULL_CYCLES < QUICK_CYCLES || TIMEOUT_CYCLES < 2) begin : gBad
    $error("bcmc_charge_ctrl: time parameters too small");
  end

  typedef enum logic [5:0] {
    CH_IDLE       = 6'b000001,
    CH_WAKE       = 6'b000010,
    CH_WAKE_PAUSE = 6'b000100,
    CH_CTRL       = 6'b001000,
    CH_CTRL_PAUSE = 6'b010000,
    CH_INHIBIT    = 6'b100000
  } bcmc_ch_state_t;

  bcmc_ch_state_t chState_r;
  bcmc_ch_state_t chState_nxt;
  logic [15:0]    chargeCurrentRequest_r;
  logic [15:0]    chargeVoltageRequest_r;
  logic           inhibit_r;
  logic           curWritten_r;
  logic           voltWritten_r;
  logic           validReq_r;
  logic           freshBattery_r;
  logic           prevPresent_r;
  logic [31:0]    timer_r;
  logic [31:0]    schedTimer_r;
  logic [31:0]    fullTimer_r;
  logic           startFull_r;
  logic           startQuick_r;
  logic [11:0]    currentDrive_r;
  logic [15:0]    voltageDrive_r;
  logic           chgOe_r;
  logic [31:0]    prdata_r;
  bcmc_range_t    range;
  bcmc_flags_t    flags;
  bcmc_probe_t    probe;
  logic           senseBusy;

  // ****************************************
  // Strap decode
  // ****************************************
  function automatic logic [11:0] clampCurrent(input logic [15:0] req, input logic [1:0] strap);
    logic [11:0] ceil;
    logic [11:0] mask;
    ceil = 12'h3FF;
    mask = 12'hFFF;
    case (strap)
      2'h0: begin ceil = 12'h3FF; mask = 12'hFFF; end
      2'h1: begin ceil = 12'h7FE; mask = 12'hFFE; end
      2'h2: begin ceil = 12'hBFC; mask = 12'hFFC; end
      default: begin ceil = 12'hFFC; mask = 12'hFFC; end
    endcase
    if (req > {4'h0, ceil}) return ceil;
    return req[11:0] & mask;
  endfunction

  // Unknown strap codes fall back to the lowest ceiling as the safe choice
  function automatic logic [15:0] voltCeiling(input logic [2:0] strap);
    case (strap)
      3'h1:    return 16'h10D0;
      3'h2:    return 16'h1150;
      3'h3:    return 16'h11A0;
      3'h4:    return 16'h1580;
      default: return 16'h1090;
    endcase
  endfunction

  function automatic logic [15:0] clampVoltage(input logic [15:0] req, input logic [2:0] strap);
    logic [15:0] ceil;
    ceil = voltCeiling(strap);
    if (req > ceil) return ceil & 16'hFFF0;
    return req & 16'hFFF0;
  endfunction

  // ****************************************
  // APB decode
  // ****************************************
  logic apbAccess;
  logic apbWrite;
  logic mapped;
  logic wrCurrent;
  logic wrVoltage;
  logic wrMode;
  logic zeroWrite;
  logic bothEvent;
  logic clearReq;

  assign apbAccess = psel && penable;
  assign apbWrite  = apbAccess && pwrite;
  assign mapped    = paddr == ADDR_CURRENT || paddr == ADDR_VOLTAGE || paddr == ADDR_MODE ||
                     paddr == ADDR_STATUS || paddr == ADDR_DRIVE;
  assign pready    = 1'b1;
  assign pslverr   = apbAccess && !mapped;
  assign wrCurrent = apbWrite && paddr == ADDR_CURRENT;
  assign wrVoltage = apbWrite && paddr == ADDR_VOLTAGE;
  assign wrMode    = apbWrite && paddr == ADDR_MODE;
  assign clearReq  = wrMode && pwdata[MODE_CLEAR];
  assign zeroWrite = (wrCurrent || wrVoltage) && pwdata[15:0] == 16'h0000;
  assign bothEvent = (curWritten_r || wrCurrent) && (voltWritten_r || wrVoltage);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      chargeCurrentRequest_r <= REQ_RESET;
      chargeVoltageRequest_r <= REQ_RESET;
      inhibit_r              <= 1'b0;
    end else if (ce) begin
      if (clearReq) begin
        chargeCurrentRequest_r <= REQ_RESET;
        chargeVoltageRequest_r <= REQ_RESET;
      end else begin
        if (wrCurrent) chargeCurrentRequest_r <= pwdata[15:0];
        if (wrVoltage) chargeVoltageRequest_r <= pwdata[15:0];
      end
      if (wrMode) inhibit_r <= pwdata[MODE_INHIBIT];
    end
  end

  // Write tracking: a write in the clearing cycle still counts
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      curWritten_r  <= 1'b0;
      voltWritten_r <= 1'b0;
    end else if (ce) begin
      curWritten_r  <= bothEvent ? 1'b0 : (curWritten_r || wrCurrent);
      voltWritten_r <= bothEvent ? 1'b0 : (voltWritten_r || wrVoltage);
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      prdata_r <= 32'h00000000;
    end else if (ce && psel && !penable) begin
      case (paddr)
        ADDR_CURRENT: prdata_r <= {16'h0000, chargeCurrentRequest_r};
        ADDR_VOLTAGE: prdata_r <= {16'h0000, chargeVoltageRequest_r};
        ADDR_MODE:    prdata_r <= {31'h00000000, inhibit_r};
        ADDR_STATUS:  prdata_r <= {18'h00000, chState_r, inputSupplyOk, alarmBlockFlag,
                                   dividedInputSense, flags};
        ADDR_DRIVE:   prdata_r <= {voltageDrive_r, 4'h0, currentDrive_r};
        default:      prdata_r <= 32'h00000000;
      endcase
    end
  end
  assign prdata = prdata_r;

  // ****************************************
  // Sense sampling schedule
  // ****************************************
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      schedTimer_r <= 32'h00000000;
      fullTimer_r  <= 32'h00000000;
      startFull_r  <= 1'b0;
      startQuick_r <= 1'b0;
    end else if (ce) begin
      startFull_r  <= 1'b0;
      startQuick_r <= 1'b0;
      if (schedTimer_r != 32'h00000000) begin
        schedTimer_r <= schedTimer_r - 32'h00000001;
      end else if (!senseBusy) begin
        if (dividedInputSense) begin
          schedTimer_r <= 32'(FAST_CYCLES - 1);
          startFull_r  <= 1'b1;
        end else begin
          schedTimer_r <= 32'(QUICK_CYCLES - 1);
          startFull_r  <= fullTimer_r < 32'(QUICK_CYCLES);
          startQuick_r <= fullTimer_r >= 32'(QUICK_CYCLES);
        end
      end
      if (dividedInputSense || startFull_r) fullTimer_r <= 32'(FULL_CYCLES - 1);
      else if (fullTimer_r != 32'h00000000) fullTimer_r <= fullTimer_r - 32'h00000001;
    end
  end

  bcmc_sense_decoder uSense (
    .clk_sys    (clk_sys),
    .rstn       (rstn),
    .ce         (ce),
    .startFull  (startFull_r),
    .startQuick (startQuick_r),
    .aboveThr   (senseAbove),
    .probe      (probe),
    .range      (range),
    .busy       (senseBusy)
  );
  assign flags = bcmc_range_flags(range);

  // ****************************************
  // Battery insertion and request validity
  // ****************************************
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      prevPresent_r  <= 1'b0;
      freshBattery_r <= 1'b0;
    end else if (ce) begin
      prevPresent_r <= flags.present;
      if (flags.present && !prevPresent_r) freshBattery_r <= 1'b1;
      else if (!flags.present || chState_r != CH_IDLE) freshBattery_r <= 1'b0;
    end
  end

  logic timeout;
  logic goodRange;
  logic badRange;
  logic adapterLost;
  logic extLow;
  logic pauseCond;
  logic reqNonzero;

  assign timeout     = timer_r == 32'h00000000;
  assign goodRange   = range == RNG_COLD || range == RNG_IDEAL || range == RNG_UNDER;
  assign badRange    = range == RNG_OVER || range == RNG_HOT;
  assign adapterLost = !dividedInputSense;
  assign extLow      = !chgOe_r && !chargerEnableIn;
  assign pauseCond   = extLow || !inputSupplyOk;
  assign reqNonzero  = chargeCurrentRequest_r != 16'h0000 && chargeVoltageRequest_r != 16'h0000;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      validReq_r <= 1'b0;
    end else if (ce) begin
      if (bothEvent && !clearReq) validReq_r <= !zeroWrite && (wrCurrent ? pwdata[15:0] != 16'h0000 :
                                                              chargeCurrentRequest_r != 16'h0000) &&
                                                (wrVoltage ? pwdata[15:0] != 16'h0000 :
                                                             chargeVoltageRequest_r != 16'h0000);
      else if (clearReq || zeroWrite || (timeout && chState_r != CH_IDLE)) validReq_r <= 1'b0;
    end
  end

  // ****************************************
  // Charge sequencing
  // ****************************************
  always_comb begin
    chState_nxt = chState_r;
    case (chState_r)
      CH_IDLE: begin
        if (goodRange && dividedInputSense && !alarmBlockFlag && !inhibit_r) begin
          if (validReq_r && reqNonzero) chState_nxt = CH_CTRL;
          else if (freshBattery_r && !validReq_r) chState_nxt = CH_WAKE;
        end
      end
      CH_WAKE, CH_WAKE_PAUSE: begin
        if (badRange || adapterLost || alarmBlockFlag || inhibit_r) chState_nxt = CH_IDLE;
        else if (timeout && (range == RNG_COLD || range == RNG_UNDER)) chState_nxt = CH_IDLE;
        else if (bothEvent) chState_nxt = zeroWrite ? CH_IDLE : CH_CTRL;
        else chState_nxt = pauseCond ? CH_WAKE_PAUSE : CH_WAKE;
      end
      CH_CTRL, CH_CTRL_PAUSE, CH_INHIBIT: begin
        if (badRange || adapterLost || alarmBlockFlag || clearReq) chState_nxt = CH_IDLE;
        else if (zeroWrite) chState_nxt = CH_IDLE;
        else if (timeout && !bothEvent) chState_nxt = CH_IDLE;
        else if (inhibit_r) chState_nxt = CH_INHIBIT;
        else chState_nxt = pauseCond ? CH_CTRL_PAUSE : CH_CTRL;
      end
      default: chState_nxt = CH_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) chState_r <= CH_IDLE;
    else if (ce) chState_r <= chState_nxt;
  end

  // Pauses keep counting so toggling the enable pin cannot stretch a timeout
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      timer_r <= 32'(TIMEOUT_CYCLES - 1);
    end else if (ce) begin
      if (chState_r == CH_IDLE || bothEvent) timer_r <= 32'(TIMEOUT_CYCLES - 1);
      else if (!timeout) timer_r <= timer_r - 32'h00000001;
    end
  end

  // ****************************************
  // Converter drive and enable pin
  // ****************************************
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      currentDrive_r <= 12'h000;
      voltageDrive_r <= 16'h0000;
      chgOe_r        <= 1'b1;
    end else if (ce) begin
      case (chState_nxt)
        CH_WAKE: begin
          currentDrive_r <= WAKE_CURRENT;
          voltageDrive_r <= clampVoltage(chargeVoltageRequest_r == 16'h0000 ? 16'hFFFF :
                                         chargeVoltageRequest_r, voltageCeilingStrap);
        end
        CH_CTRL: begin
          currentDrive_r <= clampCurrent(chargeCurrentRequest_r, currentCeilingStrap);
          voltageDrive_r <= clampVoltage(chargeVoltageRequest_r, voltageCeilingStrap);
        end
        default: begin
          currentDrive_r <= 12'h000;
          voltageDrive_r <= 16'h0000;
        end
      endcase
      // Released while charging or paused so an external pull-down is visible
      chgOe_r <= chState_nxt == CH_IDLE || chState_nxt == CH_INHIBIT;
    end
  end

  assign chargerEnableOut = 1'b0;
  assign chargerEnableOe  = chgOe_r;
  assign dividerASelect   = probe.selA;
  assign dividerBSelect   = probe.selB;
  assign thresholdIndex   = probe.thrIdx;
  assign thresholdLow     = probe.hystLow;
  assign wakeActive       = chState_r == CH_WAKE;
  assign chargeActive     = chState_r == CH_CTRL;
  assign currentDrive     = currentDrive_r;
  assign voltageDrive     = voltageDrive_r;
endmodule

// ---- test/bcmc_charge_props.sv ----
// Purpose: Port checks for charge-mode control
// Assumes: One clock domain, async active-low reset
// Notes:   Bound into bcmc_charge_ctrl
`timescale 1ns/1ps
module bcmc_charge_props (
  input wire logic        clk_sys,
  input wire logic        rstn,
  input wire logic        dividedInputSense,
  input wire logic        alarmBlockFlag,
  input wire logic [1:0]  currentCeilingStrap,
  input wire logic        dividerASelect,
  input wire logic        dividerBSelect,
  input wire logic [1:0]  thresholdIndex,
  input wire logic        wakeActive,
  input wire logic        chargeActive,
  input wire logic [11:0] currentDrive,
  input wire logic [15:0] voltageDrive
);
  // ****************
  // Checks
  // ****************
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  logic [11:0] iCeil;
  assign iCeil = currentCeilingStrap[1] ? (currentCeilingStrap[0] ? 12'hFFC : 12'hBFC)
                                        : (currentCeilingStrap[0] ? 12'h7FE : 12'h3FF);
  a_wake_fixed_current: assert property (wakeActive |-> currentDrive == 12'h050)
    else $error("wake current not fixed");
  a_wake_needs_adapter: assert property ($rose(wakeActive) |-> $past(dividedInputSense))
    else $error("wake without adapter");
  a_adapter_loss_stop: assert property (chargeActive && !dividedInputSense |-> ##[1:2] !chargeActive)
    else $error("charging kept without adapter");
  a_alarm_ends_wake: assert property (wakeActive && alarmBlockFlag |-> ##[1:2] !wakeActive)
    else $error("wake kept under alarm");
  a_one_mode_only: assert property (!(wakeActive && chargeActive))
    else $error("two charge modes at once");
  a_probe_side_ok: assert property (dividerASelect || dividerBSelect |->
    dividerASelect == thresholdIndex[1] && dividerASelect != dividerBSelect)
    else $error("wrong divider side driven");
  a_current_ceiling: assert property (chargeActive && $stable(currentCeilingStrap) |->
    currentDrive <= iCeil)
    else $error("current above ceiling");
  a_voltage_grain: assert property (chargeActive |-> voltageDrive[3:0] == 4'h0 && voltageDrive <= 16'h1580)
    else $error("voltage off grain or ceiling");
endmodule
bind bcmc_charge_ctrl bcmc_charge_props i_props (.*);

// ---- test/bcmc_sense_model.sv ----
// Purpose: Battery sense resistor seen through the comparators
// Assumes: Resistance sits mid-range, so hysteresis never matters
// Notes:   Probing from the wrong side reads a toggling level
`timescale 1ns/1ps
module bcmc_sense_model (
  input  wire logic       clk_sys,
  input  wire logic       dividerASelect,
  input  wire logic       dividerBSelect,
  input  wire logic [1:0] thresholdIndex,
  input  wire logic [2:0] rangeRank,
  output logic            senseAbove
);
  // ****************
  // Comparator
  // ****************
  logic toggle_r = 1'b0;
  logic probeOk;
  always @(posedge clk_sys) toggle_r <= ~toggle_r;
  assign probeOk = thresholdIndex[1] ? dividerASelect && !dividerBSelect :
                   dividerBSelect && !dividerASelect;
  // Rank 0 is overrange and 4 underrange
  assign senseAbove = probeOk ? {1'b0, thresholdIndex} >= rangeRank : toggle_r;
endmodule

// ---- test/battery_charge_mode_control_tb_top.sv ----
// Purpose: Self-checking bench for charge-mode control
// Assumes: Shortened time bases
// Notes:   Pin level merges device pull-down and external pull-down
`timescale 1ns/1ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin fail_count++; \
  $display("mismatch %s exp %h got %h", n, e, s); end end
module battery_charge_mode_control_tb_top import bcmc_pkg::*; ;
  // ****************
  // Bench
  // ****************
  logic        clk_sys = 1'b0, rstn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic        pready, pslverr, senseAbove, chargerEnableOut, chargerEnableOe, dividerASelect, dividerBSelect;
  logic        thresholdLow, wakeActive, chargeActive, extLow = 1'b0;
  logic        dividedInputSense = 1'b1, inputSupplyOk = 1'b1, alarmBlockFlag = 1'b0;
  logic [1:0]  currentCeilingStrap = 2'h0, thresholdIndex;
  logic [2:0]  voltageCeilingStrap = 3'h0, rangeRank = 3'h0;
  logic [7:0]  paddr = 8'h00;
  logic [11:0] currentDrive;
  logic [15:0] voltageDrive, cReq, vReq;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [4:0]  flagTab [5] = '{5'h18, 5'h09, 5'h01, 5'h05, 5'h07};
  wire         chargerEnableIn = (chargerEnableOe ? chargerEnableOut : 1'b1) && !extLow;
  int          fail_count = 0, total_checks = 0, seed = 19, cyc = 0;
  bcmc_charge_ctrl #(.FAST_CYCLES(64), .QUICK_CYCLES(64), .FULL_CYCLES(256), .TIMEOUT_CYCLES(2000)) i_dut (.*);
  bcmc_sense_model i_sense (.*);
  initial forever #50 clk_sys = ~clk_sys;
  function automatic logic [31:0] drive_exp(input logic [1:0] is, input logic [2:0] vs, input logic [15:0] c, v);
    logic [15:0] ci, vc;
    ci = is[1] ? (is[0] ? 16'h0FFC : 16'h0BFC) : (is[0] ? 16'h07FE : 16'h03FF);
    vc = (vs == 3'h1) ? 16'h10D0 : (vs == 3'h2) ? 16'h1150 : (vs == 3'h3) ? 16'h11A0 :
         (vs == 3'h4) ? 16'h1580 : 16'h1090;
    ci = (c > ci) ? ci : c & ~{14'h0, is[1], is != 2'h0};
    return {((v > vc) ? vc : v) & 16'hFFF0, 4'h0, ci[11:0]};
  endfunction
  task automatic end_sim();
    if (fail_count == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic st(input logic [5:0] s);
    apb(1'b0, ADDR_STATUS, 32'h0);
    `CHK("state", s, rd[13:8])
  endtask
  task automatic pair(input logic [15:0] c, v);
    apb(1'b1, ADDR_CURRENT, {16'h0, c});
    apb(1'b1, ADDR_VOLTAGE, {16'h0, v});
  endtask
  task automatic pause_chk(input logic [5:0] s);
    for (int k = 0; k < 2; k++) begin
      extLow <= (k == 0);
      inputSupplyOk <= (k == 0);
      tick(3);
      st(s << 1);
      extLow <= 1'b0;
      inputSupplyOk <= 1'b1;
      tick(3);
      st(s);
    end
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      end_sim();
    end
  end
  initial begin
    tick(5);
    rstn <= 1'b1;
    apb(1'b0, 8'h14, 32'h0);
    `CHK("unmapped", 1'b1, err)
    for (int r = 0; r < 5; r++) begin
      rangeRank <= 3'(r);
      tick(200);
      st((r == 1 || r == 2) ? 6'h02 : 6'h01);
      `CHK("flags", flagTab[r], rd[4:0])
      alarmBlockFlag <= (r == 2);
    end
    rangeRank <= 3'h0;
    tick(200);
    rangeRank <= 3'h1;
    for (int i = 0; i < 300 && wakeActive !== 1'b1; i++) tick(1);
    tick(1000);
    pause_chk(6'h02);
    tick(800);
    st(6'h02);
    tick(250);
    st(6'h01);
    rangeRank <= 3'h0;
    tick(200);
    rangeRank <= 3'h2;
    tick(200);
    for (int i = 0; i < 4; i++) begin
      currentCeilingStrap <= 2'(i);
      voltageCeilingStrap <= 3'($random(seed));
      cReq = (i == 0) ? 16'hFFFF : 16'($random(seed)) | 16'h0001;
      vReq = (i == 1) ? 16'hFFFF : 16'h1000 | 16'($random(seed) & 32'h0FFF);
      pair(cReq, vReq);
      st(6'h08);
      apb(1'b0, ADDR_DRIVE, 32'h0);
      `CHK("drive", drive_exp(currentCeilingStrap, voltageCeilingStrap, cReq, vReq), rd)
    end
    apb(1'b1, ADDR_MODE, 32'h1);
    st(6'h20);
    apb(1'b1, ADDR_MODE, 32'h0);
    pause_chk(6'h08);
    apb(1'b0, ADDR_DRIVE, 32'h0);
    `CHK("resume", drive_exp(currentCeilingStrap, voltageCeilingStrap, cReq, vReq), rd)
    apb(1'b1, ADDR_CURRENT, 32'h0);
    st(6'h01);
    rangeRank <= 3'h3;
    tick(200);
    pair(16'h0100, 16'h1000);
    st(6'h01);
    rangeRank <= 3'h2;
    tick(200);
    pair(16'h0100, 16'h1000);
    tick(1500);
    pair(16'h0100, 16'h1000);
    tick(1500);
    st(6'h08);
    tick(600);
    st(6'h01);
    for (int k = 0; k < 4; k++) begin
      pair(16'h0200, 16'h1100);
      st(6'h08);
      alarmBlockFlag <= (k == 0);
      dividedInputSense <= (k != 1);
      if (k == 2) apb(1'b1, ADDR_MODE, 32'h2);
      if (k == 3) rangeRank <= 3'h3;
      tick(150);
      st(6'h01);
      alarmBlockFlag <= 1'b0;
      dividedInputSense <= 1'b1;
      rangeRank <= 3'h2;
      tick(150);
    end
    end_sim();
  end
endmodule
